// ### flash_pkg.sv
// constants and types for the flash sequencer with boot mode and protection
// Contract
// [R1] array is 512 kB in four 128 kB blocks, each programmed independently
// [R2] core sees a 32-bit data path on every flash access
// [R3] reads interleave across two internal banks
// [R4] program and erase run autonomously; software starts and polls busy
// [R5] no erase suspend or resume exists
// [R6] multi-block erase only as whole-chip erase
// [R7] protection set only by software command; no high-voltage method
// [R8] read protect turns on once all four blocks are protected
// [R9] unprotect first erases the contents, then clears protection
// [R10] while read protected, external tool reads return no flash data
// [R11] typical times: program 0.5 s/block, 2 s/chip; erase 100 ms, 0.4 s
// [R12] single-chip mode fetches from internal flash after reset
// [R13] single-boot mode fetches from boot ROM after reset
// [R14] startup pin held during reset; 1 gives single-chip, 0 single-boot
// [R15] outside keeps startup and strap pins stable after mode selection
// [R16] outside holds reset at least 12 clock periods
// [R17] outside holds reset 500 us at power-on
// [R18] mode latched at reset release, held until next reset
package flash_pkg;
    localparam int ADDR_W = 17;
    localparam int DATA_W = 32;
    localparam int NBLK = 4;
    localparam int BLK_W = 2;
    localparam int WORDS = 131072;
    // an erase step clears 2**ERS_LOG aligned words, half in each bank
    localparam int ERS_LOG = 4;
    localparam int ERS_PER_BANK = 2 ** (ERS_LOG - 1);
    localparam int CLK_HZ = 100_000_000;
    localparam int PROG_BLK_MS = 500;
    localparam int PROG_CHIP_MS = 2000;
    localparam int ERASE_BLK_MS = 100;
    localparam int ERASE_CHIP_MS = 400;
    localparam int CYC_PER_MS = CLK_HZ / 1000;
    localparam int PROG_BLK_CYC = PROG_BLK_MS * CYC_PER_MS;
    localparam int PROG_CHIP_CYC = PROG_CHIP_MS * CYC_PER_MS;
    localparam int ERASE_BLK_CYC = ERASE_BLK_MS * CYC_PER_MS;
    localparam int ERASE_CHIP_CYC = ERASE_CHIP_MS * CYC_PER_MS;
    localparam logic [DATA_W-1:0] ERASED_WORD = 32'hFFFF_FFFF;
    localparam logic [DATA_W-1:0] REFUSED_WORD = 32'h0000_0000;
    localparam logic [NBLK-1:0] ALL_PROT = 4'hF;
    localparam logic [NBLK-1:0] NO_PROT = 4'h0;
    typedef enum logic [2:0] {
        CMD_NONE, CMD_PROG, CMD_ERASE_BLK, CMD_ERASE_CHIP,
        CMD_PROTECT, CMD_UNPROTECT
    } cmd_t;
    typedef enum logic {BOOT_ROM, BOOT_FLASH} boot_t;
endpackage

// ### flash_seq.sv
// flash sequencer: timed program/erase, software protection, boot select
`timescale 1ns/1ps
module flash_seq #(
    parameter int PROG_BLK_T = flash_pkg::PROG_BLK_CYC,
    parameter int PROG_CHIP_T = flash_pkg::PROG_CHIP_CYC,
    parameter int ERASE_BLK_T = flash_pkg::ERASE_BLK_CYC,
    parameter int ERASE_CHIP_T = flash_pkg::ERASE_CHIP_CYC
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // strap pins
    input wire logic boot_sel,
    input wire logic factory_strap_a,
    input wire logic factory_strap_b,
    // core read port
    input wire logic rd_req,
    input wire logic [flash_pkg::ADDR_W-1:0] rd_addr,
    input wire logic rd_ext,
    output logic rd_valid,
    output logic [flash_pkg::DATA_W-1:0] rd_data,
    // command port
    input wire logic cmd_req,
    input wire flash_pkg::cmd_t cmd_op,
    input wire logic [flash_pkg::ADDR_W-1:0] cmd_addr,
    input wire logic [flash_pkg::DATA_W-1:0] cmd_data,
    output logic busy,
    output logic done,
    // status
    output logic [flash_pkg::NBLK-1:0] blk_prot,
    output logic read_prot,
    output logic boot_from_flash,
    output logic mode_valid
);
    import flash_pkg::*;

    typedef enum {S_IDLE, S_WAIT, S_ERASE, S_UNPROT_ERASE} st_t;

    function automatic logic [BLK_W-1:0] blk_of(
        input logic [ADDR_W-1:0] a);
        blk_of = a[ADDR_W-1 -: BLK_W];
    endfunction

    // bank row i of the erase group that starts at base; it holds words 2i and 2i+1
    function automatic logic [ADDR_W-2:0] ers_row(
        input logic [ADDR_W-1:0] base, input int i);
        ers_row = {base[ADDR_W-1:ERS_LOG], (ERS_LOG-1)'(i)};
    endfunction

    // two banks interleaved on the lowest word-address bit
    logic [DATA_W-1:0] bank0 [WORDS/2];
    logic [DATA_W-1:0] bank1 [WORDS/2];

    logic boot_s1_q, boot_s2_q; // strap synchroniser
    logic rst_prev_q;
    st_t st_q, st_d;
    logic [31:0] cnt_q, cnt_d;
    cmd_t op_q, op_d;
    logic [ADDR_W-1:0] addr_q, addr_d;
    logic [DATA_W-1:0] wdat_q, wdat_d;
    logic [NBLK-1:0] prot_q, prot_d;
    logic [ADDR_W-1:0] ers_q, ers_d;
    logic busy_q, busy_d, done_q, done_d;
    logic boot_q, boot_d, mvalid_q, mvalid_d;
    logic rvalid_q, rvalid_d;
    logic rprot_q, rprot_d;
    logic [DATA_W-1:0] rdata_q, rdata_d;
    logic wr_en, ers_en;
    logic [ADDR_W-1:0] wr_addr;
    logic [DATA_W-1:0] wr_val;

    always_ff @(posedge core_clk) begin
        boot_s1_q <= boot_sel;
        boot_s2_q <= boot_s1_q;
        rst_prev_q <= sys_rst;
    end

    // boot mode: caught on the first clock after reset is released
    always_comb begin
        boot_d = boot_q;
        mvalid_d = mvalid_q;
        if (rst_prev_q && !mvalid_q) begin
            boot_d = boot_s2_q ? BOOT_FLASH : BOOT_ROM; // [R14] [R12] [R13]
            mvalid_d = 1'b1; // [R18]
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            boot_q <= 1'b0;
            mvalid_q <= 1'b0;
        end else begin
            boot_q <= boot_d;
            mvalid_q <= mvalid_d;
        end
    end

    // command sequencer; no suspend path exists once an erase starts [R5]
    always_comb begin
        st_d = st_q;
        cnt_d = cnt_q;
        op_d = op_q;
        addr_d = addr_q;
        wdat_d = wdat_q;
        prot_d = prot_q;
        ers_d = ers_q;
        busy_d = busy_q;
        done_d = 1'b0;
        wr_en = 1'b0;
        ers_en = 1'b0;
        wr_addr = addr_q;
        wr_val = wdat_q;
        case (st_q)
            S_IDLE: begin
                if (cmd_req && cmd_op != CMD_NONE) begin
                    op_d = cmd_op;
                    addr_d = cmd_addr;
                    wdat_d = cmd_data;
                    busy_d = 1'b1; // [R4]
                    case (cmd_op)
                        CMD_PROG: begin
                            cnt_d = 32'(PROG_BLK_T / (WORDS / NBLK)); // [R11]
                            st_d = S_WAIT;
                        end
                        CMD_ERASE_BLK: begin
                            cnt_d = 32'(ERASE_BLK_T); // [R11]
                            st_d = S_WAIT;
                        end
                        CMD_ERASE_CHIP: begin
                            cnt_d = 32'(ERASE_CHIP_T); // [R6] [R11]
                            st_d = S_WAIT;
                        end
                        CMD_PROTECT: begin
                            cnt_d = 32'd1; // [R7]
                            st_d = S_WAIT;
                        end
                        CMD_UNPROTECT: begin
                            cnt_d = 32'(ERASE_CHIP_T); // [R9]
                            st_d = S_WAIT;
                        end
                        default: begin
                            busy_d = 1'b0;
                        end
                    endcase
                end
            end
            S_WAIT: begin
                if (cnt_q > 32'd1) begin
                    cnt_d = cnt_q - 32'd1;
                end else begin
                    ers_d = '0;
                    if (op_q == CMD_ERASE_BLK) begin
                        ers_d = {blk_of(addr_q), {(ADDR_W-BLK_W){1'b0}}};
                    end
                    case (op_q)
                        CMD_PROG: begin
                            // a protected block ignores program [R1]
                            wr_en = !prot_q[blk_of(addr_q)];
                            busy_d = 1'b0;
                            done_d = 1'b1;
                            st_d = S_IDLE;
                        end
                        CMD_PROTECT: begin
                            prot_d[blk_of(addr_q)] = 1'b1; // [R7]
                            busy_d = 1'b0;
                            done_d = 1'b1;
                            st_d = S_IDLE;
                        end
                        CMD_UNPROTECT: st_d = S_UNPROT_ERASE; // [R9]
                        default: st_d = S_ERASE;
                    endcase
                end
            end
            S_ERASE, S_UNPROT_ERASE: begin
                // one aligned word group per cycle after the timed wait,
                // so a whole-chip sweep stays short enough to simulate
                ers_en = (st_q == S_UNPROT_ERASE)
                    || (op_q == CMD_ERASE_CHIP && prot_q == NO_PROT)
                    || (op_q == CMD_ERASE_BLK && !prot_q[blk_of(ers_q)]);
                ers_d = {ers_q[ADDR_W-1:ERS_LOG] + 1'b1, {ERS_LOG{1'b0}}};
                if ((op_q == CMD_ERASE_BLK
                     && ers_q[ADDR_W-BLK_W-1:ERS_LOG] == '1)
                    || ers_q[ADDR_W-1:ERS_LOG] == '1) begin
                    if (st_q == S_UNPROT_ERASE) begin
                        prot_d = NO_PROT; // [R9] only after erase ends
                    end
                    busy_d = 1'b0;
                    done_d = 1'b1;
                    st_d = S_IDLE;
                end
            end
            default: st_d = S_IDLE;
        endcase
        rprot_d = (prot_d == ALL_PROT); // [R8]
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            st_q <= S_IDLE;
            cnt_q <= '0;
            op_q <= CMD_NONE;
            addr_q <= '0;
            wdat_q <= '0;
            prot_q <= NO_PROT;
            ers_q <= '0;
            busy_q <= 1'b0;
            done_q <= 1'b0;
            rprot_q <= 1'b0;
        end else begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            op_q <= op_d;
            addr_q <= addr_d;
            wdat_q <= wdat_d;
            prot_q <= prot_d;
            ers_q <= ers_d;
            busy_q <= busy_d;
            done_q <= done_d;
            rprot_q <= rprot_d;
        end
    end

    // a program goes to one bank picked by the low address bit [R3];
    // an erase step clears its word group in both banks at once
    always_ff @(posedge core_clk) begin
        if (wr_en) begin
            if (wr_addr[0]) begin
                bank1[wr_addr[ADDR_W-1:1]] <= wr_val;
            end else begin
                bank0[wr_addr[ADDR_W-1:1]] <= wr_val;
            end
        end
        if (ers_en) begin
            for (int i = 0; i < ERS_PER_BANK; i++) begin
                bank0[ers_row(ers_q, i)] <= ERASED_WORD;
                bank1[ers_row(ers_q, i)] <= ERASED_WORD;
            end
        end
    end

    // read path: one cycle, 32-bit word from the interleaved banks
    always_comb begin
        rvalid_d = rd_req && !busy_q;
        rdata_d = REFUSED_WORD;
        if (rd_req && !busy_q && !(rd_ext && prot_q == ALL_PROT)) begin
            rdata_d = rd_addr[0] ? bank1[rd_addr[ADDR_W-1:1]]
                                 : bank0[rd_addr[ADDR_W-1:1]]; // [R2] [R3]
        end // [R8] [R10]
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            rvalid_q <= 1'b0;
            rdata_q <= '0;
        end else begin
            rvalid_q <= rvalid_d;
            rdata_q <= rdata_d;
        end
    end

    assign rd_valid = rvalid_q;
    assign rd_data = rdata_q;
    assign busy = busy_q;
    assign done = done_q;
    assign blk_prot = prot_q;
    assign read_prot = rprot_q; // [R8]
    assign boot_from_flash = boot_q;
    assign mode_valid = mvalid_q;

    sequence ext_read_all_prot;
        rd_req && rd_ext && !busy_q && prot_q == ALL_PROT;
    endsequence

    property ext_read_refused;
        @(posedge core_clk) disable iff (sys_rst)
        ext_read_all_prot |=> rd_valid && rd_data == REFUSED_WORD;
    endproperty

    read_refuse_a: assert property (ext_read_refused) // [R10]
        else $error("protected external read returned data");

    boot_latch_a: assert property ( // [R18]
        @(posedge core_clk) disable iff (sys_rst)
        mvalid_q && $past(mvalid_q) |-> $stable(boot_q))
        else $error("boot mode changed after latch");

    boot_select_a: assert property ( // [R14]
        @(posedge core_clk) disable iff (sys_rst)
        rst_prev_q && !mvalid_q |=> mvalid_q && boot_q == $past(boot_s2_q))
        else $error("boot mode not taken from strap");

    // the registered flag must track the block bits with no lag
    read_prot_a: assert property ( // [R8]
        @(posedge core_clk) disable iff (sys_rst)
        read_prot == (blk_prot == ALL_PROT))
        else $error("read protect does not match blocks");

    unprot_order_a: assert property ( // [R9]
        @(posedge core_clk) disable iff (sys_rst)
        $past(prot_q) != NO_PROT && prot_q == NO_PROT
        |-> $past(st_q) == S_UNPROT_ERASE)
        else $error("protection cleared without erase");

    prot_sw_a: assert property ( // [R7]
        @(posedge core_clk) disable iff (sys_rst)
        prot_q != $past(prot_q) |-> $past(busy_q))
        else $error("protection changed outside a command");

    busy_start_a: assert property ( // [R4]
        @(posedge core_clk) disable iff (sys_rst)
        st_q == S_IDLE && cmd_req && cmd_op != CMD_NONE |=> busy)
        else $error("command did not raise busy");

    done_pulse_a: assert property ( // [R4]
        @(posedge core_clk) disable iff (sys_rst)
        done |-> !busy ##1 !done)
        else $error("done not a single pulse");
endmodule // flash_seq

// ### core_model.sv
// processor core model: issues flash reads and commands, polls completion
`timescale 1ns/1ps
module core_model (
    // clock
    input wire logic core_clk,
    // read port
    output logic rd_req,
    output logic [flash_pkg::ADDR_W-1:0] rd_addr,
    output logic rd_ext,
    input wire logic rd_valid,
    input wire logic [flash_pkg::DATA_W-1:0] rd_data,
    // command port
    output logic cmd_req,
    output flash_pkg::cmd_t cmd_op,
    output logic [flash_pkg::ADDR_W-1:0] cmd_addr,
    output logic [flash_pkg::DATA_W-1:0] cmd_data,
    input wire logic busy,
    input wire logic done
);
    import flash_pkg::*;

    initial begin
        rd_req = 1'b0;
        rd_addr = '0;
        rd_ext = 1'b0;
        cmd_req = 1'b0;
        cmd_op = CMD_NONE;
        cmd_addr = '0;
        cmd_data = '0;
    end

    // released qualifiers show the inverse, so stale values never match
    task automatic read(input logic [ADDR_W-1:0] a, input logic ext,
                        output logic [DATA_W-1:0] d, output logic ok);
        int n;
        ok = 1'b0;
        d = 'x;
        @(negedge core_clk);
        rd_req = 1'b1;
        rd_addr = a;
        rd_ext = ext;
        for (n = 0; n < 3 && !ok; n++) begin
            @(negedge core_clk);
            rd_req = 1'b0;
            rd_ext = ~ext;
            rd_addr = ~a;
            if (rd_valid === 1'b1) begin
                ok = 1'b1;
                d = rd_data;
            end
        end
    endtask

    // start only, then poll done under a bound
    task automatic command(input cmd_t op, input logic [ADDR_W-1:0] a,
                           input logic [DATA_W-1:0] d, output logic ok,
                           output logic saw_busy);
        int n;
        ok = 1'b0;
        @(negedge core_clk);
        cmd_req = 1'b1;
        cmd_op = op;
        cmd_addr = a;
        cmd_data = d;
        @(negedge core_clk);
        // busy rises one cycle after the request, even for a one-cycle op
        saw_busy = (busy === 1'b1);
        cmd_req = 1'b0;
        cmd_op = CMD_NONE;
        cmd_addr = ~a;
        cmd_data = ~d;
        @(negedge core_clk);
        for (n = 0; n < 40000 && !ok; n++) begin
            if (done === 1'b1) ok = 1'b1;
            else @(negedge core_clk);
        end
    endtask
endmodule // core_model

// ### flash_boot_mode_protect_tb_top.sv
// testbench for the flash sequencer: boot select, program, erase, protect
`timescale 1ns/1ps
module flash_boot_mode_protect_tb_top;
    import flash_pkg::*;
    // reset from time zero stands in for the power-on hold; no supply here
    logic core_clk = 1'b0, sys_rst = 1'b1, boot_sel = 1'b1;
    logic factory_strap_a = 1'b1, factory_strap_b = 1'b0;
    logic rd_req, rd_ext, rd_valid, cmd_req, busy, done;
    logic read_prot, boot_from_flash, mode_valid;
    logic [ADDR_W-1:0] rd_addr, cmd_addr;
    logic [DATA_W-1:0] rd_data, cmd_data;
    logic [NBLK-1:0] blk_prot;
    cmd_t cmd_op;
    int failures = 0, comparisons = 0, cycles = 0;

    always #5 core_clk = ~core_clk;

    // short timed waits: one cycle per programmed word, few before sweeps
    flash_seq #(.PROG_BLK_T(32768), .PROG_CHIP_T(8), .ERASE_BLK_T(4),
        .ERASE_CHIP_T(8)) u_flash_seq (.core_clk(core_clk),
        .sys_rst(sys_rst), .boot_sel(boot_sel),
        .factory_strap_a(factory_strap_a), .factory_strap_b(factory_strap_b),
        .rd_req(rd_req), .rd_addr(rd_addr),
        .rd_ext(rd_ext), .rd_valid(rd_valid), .rd_data(rd_data),
        .cmd_req(cmd_req), .cmd_op(cmd_op), .cmd_addr(cmd_addr),
        .cmd_data(cmd_data), .busy(busy), .done(done),
        .blk_prot(blk_prot), .read_prot(read_prot),
        .boot_from_flash(boot_from_flash), .mode_valid(mode_valid));

    core_model u_core_model (.core_clk(core_clk), .rd_req(rd_req),
        .rd_addr(rd_addr), .rd_ext(rd_ext), .rd_valid(rd_valid),
        .rd_data(rd_data), .cmd_req(cmd_req), .cmd_op(cmd_op),
        .cmd_addr(cmd_addr), .cmd_data(cmd_data), .busy(busy),
        .done(done));

    task automatic conclude();
        if (failures == 0 && comparisons > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    always @(posedge core_clk) begin
        cycles++;
        // two chip sweeps and one block sweep need about 20000 cycles
        if (cycles == 50000) begin
            failures++;
            conclude();
        end
    end

    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            failures++;
            $display("MISMATCH %s exp %h got %h", nm, e, g);
        end
    endtask

    task automatic rst_with(input logic sel);
        @(negedge core_clk);
        sys_rst = 1'b1;
        boot_sel = sel;
        repeat (12) @(negedge core_clk);
        sys_rst = 1'b0;
        repeat (2) @(negedge core_clk);
    endtask

    task automatic rd(input logic [ADDR_W-1:0] a, input logic ext,
                      input logic [31:0] e);
        logic [DATA_W-1:0] d;
        logic ok;
        u_core_model.read(a, ext, d, ok);
        chk("rd_valid", 1, ok);
        chk("rd_data", e, d);
    endtask

    task automatic cmd(input cmd_t op, input logic [ADDR_W-1:0] a,
                       input logic [DATA_W-1:0] d);
        logic ok, sb;
        u_core_model.command(op, a, d, ok, sb);
        chk("done", 1, ok);
        chk("busy", 1, sb);
    endtask

    task automatic test_boot();
        rst_with(1'b1);
        chk("mode_valid", 1, mode_valid);
        chk("boot_flash", 1, boot_from_flash);
        boot_sel = 1'b0;
        repeat (6) @(negedge core_clk);
        chk("boot_held", 1, boot_from_flash);
        rst_with(1'b0);
        chk("boot_rom", 0, boot_from_flash);
        rst_with(1'b1);
    endtask

    task automatic test_prog_erase();
        cmd(CMD_ERASE_CHIP, '0, '0);
        rd(17'h1_FFFF, 1'b0, ERASED_WORD);
        cmd(CMD_PROG, 17'h0_0010, 32'h1234_5678);
        cmd(CMD_PROG, 17'h1_8010, 32'hA5A5_0F0F);
        rd(17'h0_0010, 1'b0, 32'h1234_5678);
        rd(17'h1_8010, 1'b0, 32'hA5A5_0F0F);
        cmd(CMD_ERASE_BLK, 17'h1_8000, '0);
        rd(17'h1_8010, 1'b0, ERASED_WORD);
        rd(17'h0_0010, 1'b0, 32'h1234_5678);
    endtask

    task automatic test_protect();
        for (int b = 0; b < NBLK; b++) begin
            chk("read_prot_part", 0, read_prot);
            cmd(CMD_PROTECT, ADDR_W'(b) << 15, '0);
        end
        chk("blk_prot", ALL_PROT, blk_prot);
        chk("read_prot", 1, read_prot);
        rd(17'h0_0010, 1'b1, REFUSED_WORD);
        rd(17'h0_0010, 1'b0, 32'h1234_5678);
        cmd(CMD_PROG, 17'h0_0020, 32'h0000_0000);
        rd(17'h0_0020, 1'b0, ERASED_WORD);
        cmd(CMD_UNPROTECT, '0, '0);
        chk("blk_unprot", NO_PROT, blk_prot);
        chk("read_unprot", 0, read_prot);
        rd(17'h0_0010, 1'b1, ERASED_WORD);
    endtask

    initial begin
        test_boot();
        test_prog_erase();
        test_protect();
        conclude();
    end
endmodule // flash_boot_mode_protect_tb_top
